// *** common/amc_pkg.sv ***
// Purpose: Shared constants and types for the async memory bus controller
// Assumes: CORE_CLK at 100 MHz (10 ns period)
// Notes:   Times kept in ns, cycle counts derived from the clock period
package amc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W        = 20;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned BYTE_W        = 8;

  // Least times round up, none below one cycle
  function automatic int unsigned amc_min_cyc(input int unsigned t_ns);
    int unsigned c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : amc_min_cyc

  localparam int unsigned MIN_CYCLE_TIME_NS      = 35;
  localparam int unsigned WRITE_PULSE_NS         = 15;
  localparam int unsigned ADDR_TO_END_NS         = 20;
  localparam int unsigned DATA_TO_END_NS         = 10;
  localparam int unsigned WRITE_RECOVERY_TIME_NS = 12;
  localparam int unsigned HIGH_HOLD_NS           = 2;
  localparam int unsigned READ_ACCESS_NS         = 35;
  localparam int unsigned OE_RELEASE_NS          = 10;
  localparam int unsigned CS_RELEASE_NS          = 15;
  localparam int unsigned STARTUP_NS             = 2000000;

  localparam int unsigned MIN_CYCLE_CYC  = amc_min_cyc(MIN_CYCLE_TIME_NS);
  localparam int unsigned WPULSE_CYC     = amc_min_cyc(WRITE_PULSE_NS);
  localparam int unsigned ADDR_END_CYC   = amc_min_cyc(ADDR_TO_END_NS);
  localparam int unsigned RECOVERY_CYC   = amc_min_cyc(WRITE_RECOVERY_TIME_NS);
  localparam int unsigned HIGH_HOLD_CYC  = amc_min_cyc(HIGH_HOLD_NS);
  // One extra cycle covers the two-stage data input synchroniser
  localparam int unsigned READ_CYC       = amc_min_cyc(READ_ACCESS_NS) + 1;
  localparam int unsigned TURN_CYC       = amc_min_cyc(CS_RELEASE_NS);
  localparam int unsigned STARTUP_CYC    = STARTUP_NS / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 8;
  localparam int unsigned SU_W  = 20;

  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 20'h00000;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        byte_en;   // [1] upper, [0] lower
  } amc_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
    logic              chip_sel_b;
    logic              write_b;
    logic              out_en_b;
    logic              upper_byte_sel_b;
    logic              lower_byte_sel_b;
  } amc_pins_t;

  typedef enum logic [2:0] {
    ST_STARTUP = 3'b000,
    ST_IDLE    = 3'b001,
    ST_SETUP   = 3'b011,
    ST_PULSE   = 3'b010,
    ST_HOLD    = 3'b110,
    ST_READ    = 3'b111,
    ST_GAP     = 3'b101
  } amc_state_t;

endpackage : amc_pkg

// *** testbench/amc_ctrl_asserts.sv ***
// Purpose: Pin timing checks for the memory controller
// Assumes: Controls change only on CORE_CLK edges
// Notes:   Nanosecond figures round up to whole cycles
`timescale 1ns/100ps
module amc_ctrl_asserts
  import amc_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = 10
)
(
  // Clock and reset
  input wire logic              CORE_CLK,
  input wire logic              RST_B,
  // Memory pins
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic [DATA_W-1:0] MEM_DQ_O,
  input wire logic              MEM_DQ_OE,
  input wire logic              MEM_CHIP_SEL_B,
  input wire logic              MEM_WRITE_B,
  input wire logic              MEM_OUT_EN_B,
  input wire logic              MEM_UPPER_BYTE_SEL_B,
  input wire logic              MEM_LOWER_BYTE_SEL_B
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  logic [2:0]      gap_q;
  logic [SU_W-1:0] su_q;
  // Counters saturate so a long idle never wraps into a false alarm
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      gap_q <= 3'h7;
      su_q  <= 20'h00000;
    end else begin
      gap_q <= $fell(MEM_CHIP_SEL_B) ? 3'h1 : gap_q + {2'h0, gap_q != 3'h7};
      su_q  <= su_q + {19'h00000, su_q != 20'hFFFFF};
    end
  end
  a_write_in_select: assert property (
    $fell(MEM_WRITE_B) |-> !MEM_CHIP_SEL_B) else $error("strobe unselected");
  a_read_strobe_high: assert property (
    !MEM_OUT_EN_B |-> MEM_WRITE_B && !MEM_DQ_OE) else $error("read strobe");
  a_select_high_hold: assert property (
    $rose(MEM_CHIP_SEL_B) |=> MEM_CHIP_SEL_B) else $error("select glitch");
  a_lane_skew: assert property (
    $fell(MEM_UPPER_BYTE_SEL_B) && !MEM_LOWER_BYTE_SEL_B
    |-> $fell(MEM_LOWER_BYTE_SEL_B)) else $error("lane skew");
  a_cycle_space: assert property (
    $fell(MEM_CHIP_SEL_B) |-> gap_q >= MIN_CYCLE_CYC) else $error("cycle");
  a_pulse_width: assert property (
    $fell(MEM_WRITE_B) |=> !MEM_WRITE_B) else $error("short pulse");
  a_addr_to_end: assert property (
    $rose(MEM_WRITE_B) |-> MEM_ADDR == $past(MEM_ADDR, 2))
    else $error("address late");
  a_data_to_end: assert property (
    $rose(MEM_WRITE_B) |-> MEM_DQ_OE && $stable(MEM_DQ_O))
    else $error("data late");
  a_addr_recover: assert property (
    $rose(MEM_WRITE_B) |=> $stable(MEM_ADDR)) else $error("address hold");
  a_startup_idle: assert property (
    su_q < STARTUP_CYCLES |-> MEM_CHIP_SEL_B && MEM_WRITE_B)
    else $error("startup access");
  c_write: cover property ($rose(MEM_WRITE_B));
  c_read: cover property ($rose(MEM_OUT_EN_B));
  c_one_lane: cover property (!MEM_WRITE_B && MEM_UPPER_BYTE_SEL_B);
endmodule : amc_ctrl_asserts

// *** testbench/amc_ctrl_test.sv ***
// Purpose: Self-checking bench for the memory controller
// Assumes: Short startup count keeps the run brief
// Notes:   Reads are judged against what was written before
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  err_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module amc_ctrl_test
  import amc_pkg::*;
;
  localparam int unsigned SU = 10;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              req_valid = 1'b0;
  amc_req_t          req = '0;
  logic              ready, rsp_valid, dq_oe, cs_b, we_b, oe_b, ub_b, lb_b;
  logic [DATA_W-1:0] rsp_data, dq, dq_o;
  logic [ADDR_W-1:0] addr;
  int                err_count = 0;
  int                tests_run = 0;
  always #5 clk = ~clk;
  amc_ctrl #(.STARTUP_CYCLES(SU)) i_amc_ctrl (.CORE_CLK(clk), .RST_B(rst_b),
    .REQ_VALID(req_valid), .REQ_READY(ready), .REQ(req),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .MEM_ADDR(addr),
    .MEM_DQ_I(dq), .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe),
    .MEM_CHIP_SEL_B(cs_b), .MEM_WRITE_B(we_b), .MEM_OUT_EN_B(oe_b),
    .MEM_UPPER_BYTE_SEL_B(ub_b), .MEM_LOWER_BYTE_SEL_B(lb_b));
  amc_mem_model i_amc_mem_model (.addr(addr), .ctl_dq(dq_o),
    .ctl_dq_oe(dq_oe), .chip_sel_b(cs_b), .write_b(we_b), .out_en_b(oe_b),
    .upper_byte_sel_b(ub_b), .lower_byte_sel_b(lb_b), .dq(dq));
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // Request held until taken; reads wait for the one-cycle answer
  task automatic do_op(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic [1:0] be,
      output logic [DATA_W-1:0] q);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{write: wr, addr: a, wdata: d, byte_en: be};
    do @(posedge clk); while (ready !== 1'b1 && ++n < 50);
    req_valid <= 1'b0;
    while (!wr && rsp_valid !== 1'b1 && ++n < 50) @(posedge clk);
    if (n >= 50) err_count++;
    q = rsp_data;
  endtask : do_op
  task automatic t_startup;
    @(posedge clk);
    req_valid <= 1'b1;
    repeat (SU - 2) begin
      @(posedge clk);
      `CHK("startup select", 1'b1, cs_b)
    end
    req_valid <= 1'b0;
  endtask : t_startup
  task automatic t_words;
    logic [ADDR_W-1:0] a [3] = '{20'h00000, 20'hFFFFF, 20'h5A5A5};
    logic [DATA_W-1:0] q;
    for (int i = 0; i < 3; i++) do_op(1'b1, a[i], a[i][15:0] ^ 16'h3C96, 2'h3, q);
    for (int i = 0; i < 3; i++) begin
      do_op(1'b0, a[i], 16'h0000, 2'h3, q);
      `CHK("word", a[i][15:0] ^ 16'h3C96, q)
    end
  endtask : t_words
  task automatic t_lanes;
    logic [DATA_W-1:0] q;
    do_op(1'b1, 20'h00F0F, 16'hA5C3, 2'h3, q);
    do_op(1'b1, 20'h00F0F, 16'h1234, 2'h1, q);
    do_op(1'b0, 20'h00F0F, 16'h0000, 2'h1, q);
    `CHK("low lane", 8'h34, q[7:0])
    do_op(1'b1, 20'h00F0F, 16'h7E00, 2'h2, q);
    do_op(1'b0, 20'h00F0F, 16'h0000, 2'h3, q);
    `CHK("both lanes", 16'h7E34, q)
  endtask : t_lanes
  task automatic t_mid_reset;
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{write: 1'b1, addr: 20'h00001, wdata: 16'hBEEF, byte_en: 2'h3};
    while (we_b !== 1'b0 && ++n < 50) @(posedge clk);
    rst_b <= 1'b0;
    req_valid <= 1'b0;
    @(posedge clk);
    `CHK("pins in reset", 3'h7, {cs_b, we_b, ~dq_oe})
    rst_b <= 1'b1;
    t_startup();
  endtask : t_mid_reset
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_startup();
    t_words();
    t_lanes();
    t_mid_reset();
    t_lanes();
    tally_and_finish();
  end
  // Whole run is a few hundred cycles; allow over twenty times that
  initial begin
    #50000;
    err_count++;
    tally_and_finish();
  end
endmodule : amc_ctrl_test
bind amc_ctrl amc_ctrl_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES))
  i_amc_ctrl_asserts (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
  .MEM_ADDR(MEM_ADDR), .MEM_DQ_O(MEM_DQ_O), .MEM_DQ_OE(MEM_DQ_OE),
  .MEM_CHIP_SEL_B(MEM_CHIP_SEL_B), .MEM_WRITE_B(MEM_WRITE_B),
  .MEM_OUT_EN_B(MEM_OUT_EN_B), .MEM_UPPER_BYTE_SEL_B(MEM_UPPER_BYTE_SEL_B),
  .MEM_LOWER_BYTE_SEL_B(MEM_LOWER_BYTE_SEL_B));

// *** testbench/amc_mem_model.sv ***
// Purpose: Behavioural async memory beside the controller
// Assumes: Word store, lanes gated by the byte selects
// Notes:   Released lanes show the inverse of their last level
`timescale 1ns/100ps
module amc_mem_model
  import amc_pkg::*;
#(
  parameter int unsigned RD_NS = 30
)
(
  // Controller pins
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] ctl_dq,
  input  wire logic              ctl_dq_oe,
  input  wire logic              chip_sel_b,
  input  wire logic              write_b,
  input  wire logic              out_en_b,
  input  wire logic              upper_byte_sel_b,
  input  wire logic              lower_byte_sel_b,
  // Resolved data wire
  output wire logic [DATA_W-1:0] dq
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] rd_now;
  logic [DATA_W-1:0] rd_late;
  logic [7:0]        last_q [2] = '{8'hA5, 8'h5A};
  logic              rd_on_d;
  wire [1:0] sel_b = {upper_byte_sel_b, lower_byte_sel_b};
  wire       wr_on = !chip_sel_b && !write_b;
  // Strobe low never drives, so a late enable stays quiet
  wire       rd_on = !chip_sel_b && !out_en_b && write_b;
  assign #3 rd_on_d = rd_on;
  assign #(RD_NS) rd_late = rd_now;
  always @(addr or negedge out_en_b or negedge chip_sel_b) begin
    rd_now = mem.exists(addr) ? mem[addr] : ~addr[15:0];
  end
  for (genvar i = 0; i < 2; i++) begin : g_lane
    wire drv = rd_on && rd_on_d && !sel_b[i];
    assign dq[i*8+:8] = ctl_dq_oe ? ctl_dq[i*8+:8]
                      : drv ? rd_late[i*8+:8] : ~last_q[i];
    always @(dq[i*8+:8]) begin
      if (ctl_dq_oe || drv) last_q[i] = dq[i*8+:8];
    end
    always @* begin
      if (wr_on && !sel_b[i]) mem[addr][i*8+:8] = dq[i*8+:8];
    end
  end
endmodule : amc_mem_model

// *** verilog/amc_ctrl.sv ***
// Purpose: Host controller for a 1M x 16 asynchronous SRAM-style memory
// Assumes: Single clock, memory pins driven straight from flip-flops
// Notes:   Each write is terminated by strobe and select rising together
//
// Overview of operation
// - Write happens while select and strobe low
// - Strobe stays high during reads
// - Address valid by select falling edge
// - Raised controls stay high 2 ns
// - Both byte selects skew at most 2 ns
// - Cycles and select edges spaced 35 ns
// - Write control low at least 15 ns
// - Address at pulse start, 20 ns before end
// - Data valid 10 ns before end
// - Address held 12 ns after write
// - Controls high, idle for 2 ms startup
`timescale 1ns/100ps
module amc_ctrl
  import amc_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYC
)
(
  // Clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RST_B,
  // Request side
  input  wire logic              REQ_VALID,
  output wire logic              REQ_READY,
  input  wire amc_req_t          REQ,
  // Read answer
  output wire logic              RSP_VALID,
  output wire logic [DATA_W-1:0] RSP_DATA,
  // Memory pins
  output wire logic [ADDR_W-1:0] MEM_ADDR,
  input  wire logic [DATA_W-1:0] MEM_DQ_I,
  output wire logic [DATA_W-1:0] MEM_DQ_O,
  output wire logic              MEM_DQ_OE,
  output wire logic              MEM_CHIP_SEL_B,
  output wire logic              MEM_WRITE_B,
  output wire logic              MEM_OUT_EN_B,
  output wire logic              MEM_UPPER_BYTE_SEL_B,
  output wire logic              MEM_LOWER_BYTE_SEL_B
);

  amc_state_t        state_q;
  amc_state_t        state_d;
  amc_pins_t         pins_q;
  amc_pins_t         pins_d;
  amc_req_t          req_q;
  logic [SU_W-1:0]   su_cnt_q;
  logic [DATA_W-1:0] dq_s1_q;
  logic [DATA_W-1:0] dq_s2_q;
  logic [DATA_W-1:0] rdata_q;
  logic              rvalid_q;
  logic              tmr_load;
  logic [CNT_W-1:0]  tmr_value;
  logic              tmr_done;
  logic [CNT_W-1:0]  gap_cyc;
  wire               su_done = (su_cnt_q == SU_W'(STARTUP_CYCLES));
  wire               accept  = (state_q == ST_IDLE) && REQ_VALID;
  wire               rd_end  = (state_q == ST_READ) && tmr_done;

  // Cast a cycle count to the timer width
  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    return CNT_W'(n);
  endfunction : cyc

  // Remaining gap so select falls are at least a full cycle apart
  assign gap_cyc = req_q.write
    ? cyc(MIN_CYCLE_CYC > WPULSE_CYC + RECOVERY_CYC ?
          MIN_CYCLE_CYC - WPULSE_CYC - RECOVERY_CYC : HIGH_HOLD_CYC)
    : cyc(TURN_CYC);

  assign REQ_READY = (state_q == ST_IDLE);

  always_comb begin
    state_d   = state_q;
    tmr_load  = 1'b0;
    tmr_value = CNT_ZERO;
    case (state_q)
      ST_STARTUP: begin
        if (su_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (REQ_VALID) begin
          tmr_load  = 1'b1;
          // Address stands two cycles before the write strobe
          tmr_value = CNT_ONE;
          state_d   = REQ.write ? ST_SETUP : ST_READ;
          if (!REQ.write) begin
            tmr_value = cyc(READ_CYC);
          end
        end
      end
      ST_SETUP: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          // Pulse covers both strobe width and address-to-end time
          tmr_value = cyc(ADDR_END_CYC > WPULSE_CYC + 1 ?
                          ADDR_END_CYC - 1 : WPULSE_CYC);
          state_d  = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_value = cyc(RECOVERY_CYC);
          state_d   = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_value = gap_cyc;
          state_d   = ST_GAP;
        end
      end
      ST_READ: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_value = gap_cyc;
          state_d   = ST_GAP;
        end
      end
      ST_GAP: begin
        if (tmr_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_STARTUP;
      end
    endcase
  end

  // Pin image for the next cycle
  always_comb begin
    pins_d                  = pins_q;
    pins_d.write_b          = 1'b1;
    case (state_d)
      ST_SETUP: begin
        // Latch only on entry; the request may change once taken
        if (state_q == ST_IDLE) begin
          pins_d.addr             = REQ.addr;
          pins_d.chip_sel_b       = 1'b0;
          pins_d.upper_byte_sel_b = ~REQ.byte_en[1];
          pins_d.lower_byte_sel_b = ~REQ.byte_en[0];
          pins_d.out_en_b         = 1'b1;
          pins_d.dq_out           = REQ.wdata;
          pins_d.dq_oe            = 1'b1;
        end
      end
      ST_PULSE: begin
        // Select stays low through the pulse; it rises with the strobe to end the write
        pins_d.write_b = 1'b0;
      end
      ST_HOLD: begin
        // Select rises with the strobe; address and data stay put
        pins_d.chip_sel_b       = 1'b1;
        pins_d.upper_byte_sel_b = 1'b1;
        pins_d.lower_byte_sel_b = 1'b1;
      end
      ST_READ: begin
        if (state_q == ST_IDLE) begin
          // Address and select change on the same edge
          pins_d.addr             = REQ.addr;
          pins_d.chip_sel_b       = 1'b0;
          pins_d.out_en_b         = 1'b0;
          pins_d.upper_byte_sel_b = ~REQ.byte_en[1];
          pins_d.lower_byte_sel_b = ~REQ.byte_en[0];
          pins_d.dq_oe            = 1'b0;
        end
      end
      default: begin
        pins_d.chip_sel_b       = 1'b1;
        pins_d.out_en_b         = 1'b1;
        pins_d.upper_byte_sel_b = 1'b1;
        pins_d.lower_byte_sel_b = 1'b1;
        pins_d.dq_oe            = 1'b0;
      end
    endcase
  end

  amc_timer u_timer (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .load  (tmr_load),
    .value (tmr_value),
    .done  (tmr_done)
  );

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= ST_STARTUP;
      su_cnt_q <= {SU_W{1'b0}};
    end else begin
      state_q <= state_d;
      su_cnt_q <= su_done ? su_cnt_q : su_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pins_q <= '{addr: ADDR_ZERO, dq_out: DATA_ZERO, dq_oe: 1'b0,
                  chip_sel_b: 1'b1, write_b: 1'b1, out_en_b: 1'b1,
                  upper_byte_sel_b: 1'b1, lower_byte_sel_b: 1'b1};
      req_q  <= '0;
    end else begin
      pins_q <= pins_d;
      req_q  <= accept ? REQ : req_q;
    end
  end

  // Data pins come from another timing domain, so two stages first
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dq_s1_q  <= DATA_ZERO;
      dq_s2_q  <= DATA_ZERO;
      rdata_q  <= DATA_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      dq_s1_q  <= MEM_DQ_I;
      dq_s2_q  <= dq_s1_q;
      rvalid_q <= rd_end;
      rdata_q  <= rd_end ? dq_s2_q : rdata_q;
    end
  end

  assign RSP_VALID            = rvalid_q;
  assign RSP_DATA             = rdata_q;
  assign MEM_ADDR             = pins_q.addr;
  assign MEM_DQ_O             = pins_q.dq_out;
  assign MEM_DQ_OE            = pins_q.dq_oe;
  assign MEM_CHIP_SEL_B       = pins_q.chip_sel_b;
  assign MEM_WRITE_B          = pins_q.write_b;
  assign MEM_OUT_EN_B         = pins_q.out_en_b;
  assign MEM_UPPER_BYTE_SEL_B = pins_q.upper_byte_sel_b;
  assign MEM_LOWER_BYTE_SEL_B = pins_q.lower_byte_sel_b;

endmodule : amc_ctrl

// *** verilog/amc_timer.sv ***
// Purpose: Down counter that reports when a programmed interval expires
// Assumes: Load and count share one clock
// Notes:   Done is high while the count is zero
`timescale 1ns/100ps
module amc_timer
  import amc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Control
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] value,
  // Status
  output wire logic             done
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  assign done  = (cnt_q == CNT_ZERO);
  assign cnt_d = load ? value : (done ? cnt_q : cnt_q - CNT_ONE);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : amc_timer
